//--- bench/system_clock_select_bench.sv
// Self-checking bench for the system clock select block.
// Assumes free-running oscillator levels made here, far below half the bus clock.
module system_clock_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF [5] = '{2, 3, 4, 5, 6};
    localparam int RATIO [8] = '{32, 16, 8, 4, 2, 1, 1, 1};
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic idle_mode = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [3:0] wstrb = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [4:0] osc = 5'h00;
    logic awready, wready, bvalid, arready, rvalid, sys_clk_out, clk_prev;
    logic [31:0] rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic [6:0] en_out;
    int cyc = 0;
    int run_len = 8;
    int miscompares = 0;
    int samples_checked = 0;

    system_clock_select u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .idle_mode(idle_mode),
        .internal_fast_rc_osc(osc[0]), .fast_crystal_osc(osc[1]),
        .alternative_rc_fast_osc(osc[2]), .internal_slow_rc_osc(osc[3]),
        .slow_crystal_osc(osc[4]), .internal_fast_rc_en(en_out[6]),
        .fast_crystal_en(en_out[5]), .alternative_rc_fast_en(en_out[4]),
        .internal_slow_rc_en(en_out[3]), .slow_crystal_en(en_out[2]),
        .fast_crystal_pins(en_out[1]), .slow_crystal_pins(en_out[0]),
        .sys_clk_out(sys_clk_out));

    always #4 ref_clk = ~ref_clk;

    // Every source runs all the time, so a switch never waits on a dead oscillator.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 5; i++) begin
            osc[i] <= ((cyc / HALF[i]) % 2) == 1;
        end
    end

    // The fastest phase any source can give is two cycles; anything shorter is a runt.
    always @(posedge ref_clk) begin
        clk_prev <= sys_clk_out;
        if (rst_n !== 1'b1) begin
            run_len <= 8;
        end else if (sys_clk_out !== clk_prev) begin
            check(32'(run_len >= 2), 32'h1);
            run_len <= 1;
        end else begin
            run_len <= run_len + 1;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk);
            if (!aw_done && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (!w_done && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        while (bvalid !== 1'b1) @(posedge ref_clk);
        r = bresp;
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge ref_clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask : axi_read

    task automatic wr(input logic [7:0] d);
        axi_write(clk_sel_pkg::CTRL_OFFSET, {24'h0, d}, 4'hf, rs);
        check({30'h0, rs}, {30'h0, clk_sel_pkg::RESP_OKAY});
    endtask : wr

    task automatic expect_reg(input logic [3:0] a, input logic [31:0] exp);
        axi_read(a, rd, rs);
        check(rd, exp);
        check({30'h0, rs}, {30'h0, clk_sel_pkg::RESP_OKAY});
    endtask : expect_reg

    // Polls the switch-pending flag; a hung switch shows up in the status compare after.
    task automatic settle();
        int n;
        n = 0;
        do begin
            axi_read(clk_sel_pkg::STATUS_OFFSET, rd, rs);
            n++;
        end while (rd[6] !== 1'b0 && n < 400);
    endtask : settle

    task automatic status_is(input logic [2:0] psc, input logic [2:0] src);
        settle();
        expect_reg(clk_sel_pkg::STATUS_OFFSET, {26'h0, psc, src});
    endtask : status_is

    task automatic period(input int exp);
        int n;
        n = 0;
        while (sys_clk_out !== 1'b1) @(posedge ref_clk);
        while (sys_clk_out !== 1'b0) @(posedge ref_clk);
        do begin @(posedge ref_clk); n++; end while (sys_clk_out !== 1'b1);
        do begin @(posedge ref_clk); n++; end while (sys_clk_out !== 1'b0);
        check(32'(n), 32'(exp));
    endtask : period

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        #500000;
        miscompares++;
        final_report();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        check({25'h0, en_out}, 32'h48);
        expect_reg(clk_sel_pkg::CTRL_OFFSET, {24'h0, clk_sel_pkg::CTRL_RESET});
        status_is(clk_sel_pkg::PSC_RESET, clk_sel_pkg::SEL_SRC);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            wr({5'h00, 3'(c)});
            status_is(3'(c), clk_sel_pkg::SEL_SRC);
            period(RATIO[c] * 2 * HALF[3]);
        end
        $display("test prescaler done");
        wr(8'h54);
        check({30'h0, en_out[1:0]}, 32'h3);
        status_is(clk_sel_pkg::PSC_DIV2, clk_sel_pkg::SEL_SXT);
        period(2 * 2 * HALF[4]);
        wr(8'h74);
        status_is(clk_sel_pkg::PSC_DIV2, clk_sel_pkg::SEL_FXT);
        period(2 * 2 * HALF[1]);
        check({30'h0, en_out[6:5]}, 32'h1);
        wr(8'hf4);
        expect_reg(clk_sel_pkg::CTRL_OFFSET, 32'h74);
        $display("test crystal and mode done");
        wr(8'h54);
        status_is(clk_sel_pkg::PSC_DIV2, clk_sel_pkg::SEL_SXT);
        wr(8'h5c);
        repeat (2) @(posedge ref_clk);
        check({30'h0, en_out[6:5]}, 32'h0);
        wr(8'h7c);
        expect_reg(clk_sel_pkg::CTRL_OFFSET, 32'h5c);
        // The alternative oscillator already runs before it is chosen.
        wr(8'hdc);
        wr(8'hfc);
        expect_reg(clk_sel_pkg::CTRL_OFFSET, 32'hfc);
        status_is(clk_sel_pkg::PSC_DIV2, clk_sel_pkg::SEL_RFC);
        check({25'h0, en_out}, 32'h37);
        period(2 * 2 * HALF[2]);
        $display("test stop and alternative done");
        wr(8'hdc);
        wr(8'h14);
        wr(8'h34);
        expect_reg(clk_sel_pkg::CTRL_OFFSET, 32'h34);
        status_is(clk_sel_pkg::PSC_DIV2, clk_sel_pkg::SEL_FRC);
        period(2 * 2 * HALF[0]);
        wr(8'h3c);
        repeat (2) @(posedge ref_clk);
        check({30'h0, en_out[6:5]}, 32'h2);
        idle_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check({30'h0, en_out[6:5]}, 32'h0);
        idle_mode <= 1'b0;
        $display("test fast rc and idle done");
        axi_read(4'h8, rd, rs);
        check(rd, 32'h0);
        check({30'h0, rs}, {30'h0, clk_sel_pkg::RESP_SLVERR});
        axi_write(clk_sel_pkg::STATUS_OFFSET, 32'h07, 4'hf, rs);
        check({30'h0, rs}, {30'h0, clk_sel_pkg::RESP_SLVERR});
        axi_write(clk_sel_pkg::CTRL_OFFSET, 32'h00, 4'h0, rs);
        check({30'h0, rs}, {30'h0, clk_sel_pkg::RESP_OKAY});
        expect_reg(clk_sel_pkg::CTRL_OFFSET, 32'h3c);
        $display("test bus errors done");
        final_report();
    end
endmodule : system_clock_select_bench

//--- rtl/clk_sel_pkg.sv
// Constants, register layout and source codes of the system clock select block.
// Assumes one 125 MHz bus clock and oscillator levels sampled in that domain.
package clk_sel_pkg;

    localparam int ADDR_W = 4;
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    localparam int FTYPE_BIT = 7;
    localparam int FSUB_BIT = 6;
    localparam int MODE_BIT = 5;
    localparam int STYPE_BIT = 4;
    localparam int STOP_BIT = 3;
    localparam int PSC_MSB = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Source codes index the oscillator level vector.
    localparam logic [2:0] SEL_FRC = 3'h0;
    localparam logic [2:0] SEL_FXT = 3'h1;
    localparam logic [2:0] SEL_RFC = 3'h2;
    localparam logic [2:0] SEL_SRC = 3'h3;
    localparam logic [2:0] SEL_SXT = 3'h4;

    localparam logic [2:0] PSC_DIV32 = 3'h0;
    localparam logic [2:0] PSC_DIV16 = 3'h1;
    localparam logic [2:0] PSC_DIV8 = 3'h2;
    localparam logic [2:0] PSC_DIV4 = 3'h3;
    localparam logic [2:0] PSC_DIV2 = 3'h4;
    localparam logic [2:0] PSC_RESET = 3'h0;

    // Edges per half period, minus one, for each divide ratio.
    localparam logic [4:0] HALF_M1_DIV32 = 5'h1f;
    localparam logic [4:0] HALF_M1_DIV16 = 5'h0f;
    localparam logic [4:0] HALF_M1_DIV8 = 5'h07;
    localparam logic [4:0] HALF_M1_DIV4 = 5'h03;
    localparam logic [4:0] HALF_M1_DIV2 = 5'h01;
    localparam logic [4:0] HALF_M1_DIV1 = 5'h00;

    typedef enum logic [1:0] {
        st_run = 2'b01,
        st_switch = 2'b10
    } sw_state_e;

endpackage : clk_sel_pkg

//--- rtl/system_clock_select.sv
// System clock source select with prescaler and an AXI4-Lite register slave.
// Oscillator levels arrive already synchronous to ref_clk; the system clock
// is rebuilt from their sampled edges, so each source must run below 62.5 MHz.
module system_clock_select (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic awvalid,
    output logic awready,
    input wire logic [3:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [3:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic idle_mode,
    input wire logic internal_fast_rc_osc,
    input wire logic fast_crystal_osc,
    input wire logic alternative_rc_fast_osc,
    input wire logic internal_slow_rc_osc,
    input wire logic slow_crystal_osc,
    output logic internal_fast_rc_en,
    output logic fast_crystal_en,
    output logic alternative_rc_fast_en,
    output logic internal_slow_rc_en,
    output logic slow_crystal_en,
    output logic fast_crystal_pins,
    output logic slow_crystal_pins,
    output logic sys_clk_out
);

    function automatic logic [4:0] half_m1(input logic [2:0] psc);
        case (psc)
            clk_sel_pkg::PSC_DIV32: half_m1 = clk_sel_pkg::HALF_M1_DIV32;
            clk_sel_pkg::PSC_DIV16: half_m1 = clk_sel_pkg::HALF_M1_DIV16;
            clk_sel_pkg::PSC_DIV8: half_m1 = clk_sel_pkg::HALF_M1_DIV8;
            clk_sel_pkg::PSC_DIV4: half_m1 = clk_sel_pkg::HALF_M1_DIV4;
            clk_sel_pkg::PSC_DIV2: half_m1 = clk_sel_pkg::HALF_M1_DIV2;
            default: half_m1 = clk_sel_pkg::HALF_M1_DIV1;
        endcase
    endfunction : half_m1

    function automatic logic src_level(input logic [2:0] sel, input logic [4:0] lv);
        case (sel)
            clk_sel_pkg::SEL_FRC: src_level = lv[0];
            clk_sel_pkg::SEL_FXT: src_level = lv[1];
            clk_sel_pkg::SEL_RFC: src_level = lv[2];
            clk_sel_pkg::SEL_SRC: src_level = lv[3];
            default: src_level = lv[4];
        endcase
    endfunction : src_level

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic aw_full_reg;
    logic w_full_reg;
    logic [3:0] awaddr_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic wr_fire;
    logic ctrl_wr;
    clk_sel_pkg::sw_state_e state_reg;
    logic [2:0] active_src_reg;
    logic [2:0] active_psc_reg;
    logic [4:0] edge_cnt_reg;
    logic lvl_prev_reg;
    logic [2:0] req_src;
    logic [4:0] osc_vec;
    logic lvl;
    logic src_edge;
    logic tog;
    logic halt;
    logic active_slow;
    logic mode;
    logic ftype;
    logic fsub;
    logic stype;
    logic stop;
    logic [2:0] psc;

    assign mode = ctrl_reg[clk_sel_pkg::MODE_BIT];
    assign ftype = ctrl_reg[clk_sel_pkg::FTYPE_BIT];
    assign fsub = ctrl_reg[clk_sel_pkg::FSUB_BIT];
    assign stype = ctrl_reg[clk_sel_pkg::STYPE_BIT];
    assign stop = ctrl_reg[clk_sel_pkg::STOP_BIT];
    assign psc = ctrl_reg[clk_sel_pkg::PSC_MSB:0];

    assign wr_fire = aw_full_reg && w_full_reg && !bvalid;
    assign ctrl_wr = wr_fire && (awaddr_reg == clk_sel_pkg::CTRL_OFFSET) && wstrb0_reg;

    // Write channels are taken independently and held until the response is accepted.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
            bvalid <= 1'b0;
            bresp <= clk_sel_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full_reg <= 1'b1;
                wdata_reg <= wdata[7:0];
                wstrb0_reg <= wstrb[0];
                wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid <= 1'b1;
                if (awaddr_reg == clk_sel_pkg::CTRL_OFFSET) begin
                    bresp <= clk_sel_pkg::RESP_OKAY;
                end else begin
                    bresp <= clk_sel_pkg::RESP_SLVERR;
                end
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Gated bits keep their old value; the rest of the write still lands.
    always_comb begin
        ctrl_next = wdata_reg;
        if (mode) begin
            ctrl_next[clk_sel_pkg::FTYPE_BIT] = ftype;
        end
        if (stop && !ftype) begin
            ctrl_next[clk_sel_pkg::MODE_BIT] = mode;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_reg <= clk_sel_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= clk_sel_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= clk_sel_pkg::RESP_OKAY;
            if (araddr == clk_sel_pkg::CTRL_OFFSET) begin
                rdata <= {24'h0, ctrl_reg};
            end else if (araddr == clk_sel_pkg::STATUS_OFFSET) begin
                rdata <= {25'h0, state_reg == clk_sel_pkg::st_switch,
                          active_psc_reg, active_src_reg};
            end else begin
                rdata <= 32'h0;
                rresp <= clk_sel_pkg::RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    always_comb begin
        if (mode) begin
            if (ftype) begin
                req_src = clk_sel_pkg::SEL_RFC;
            end else if (fsub) begin
                req_src = clk_sel_pkg::SEL_FXT;
            end else begin
                req_src = clk_sel_pkg::SEL_FRC;
            end
        end else if (stype) begin
            req_src = clk_sel_pkg::SEL_SXT;
        end else begin
            req_src = clk_sel_pkg::SEL_SRC;
        end
    end

    assign osc_vec = {slow_crystal_osc, internal_slow_rc_osc, alternative_rc_fast_osc,
                      fast_crystal_osc, internal_fast_rc_osc};
    assign lvl = src_level(active_src_reg, osc_vec);
    assign src_edge = lvl != lvl_prev_reg;
    assign tog = src_edge && (edge_cnt_reg == half_m1(active_psc_reg));

    // A new source or ratio is taken only at the falling edge of the output,
    // so the old high phase ends whole and the new low phase is counted whole.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= clk_sel_pkg::st_run;
            active_src_reg <= clk_sel_pkg::SEL_SRC;
            active_psc_reg <= clk_sel_pkg::PSC_RESET;
            edge_cnt_reg <= 5'h00;
            // Track the source level through reset so no false edge follows release.
            lvl_prev_reg <= lvl;
            sys_clk_out <= 1'b0;
        end else begin
            lvl_prev_reg <= lvl;
            if (tog) begin
                edge_cnt_reg <= 5'h00;
                sys_clk_out <= !sys_clk_out;
            end else if (src_edge) begin
                edge_cnt_reg <= edge_cnt_reg + 5'h01;
            end
            case (state_reg)
                clk_sel_pkg::st_run: begin
                    if (req_src != active_src_reg || psc != active_psc_reg) begin
                        state_reg <= clk_sel_pkg::st_switch;
                    end
                end
                clk_sel_pkg::st_switch: begin
                    if (tog && sys_clk_out) begin
                        active_src_reg <= req_src;
                        active_psc_reg <= psc;
                        lvl_prev_reg <= src_level(req_src, osc_vec);
                        state_reg <= clk_sel_pkg::st_run;
                    end
                end
                default: state_reg <= clk_sel_pkg::st_run;
            endcase
        end
    end

    // Outside idle_mode the halt waits until the slow clock is really driving the output, so a
    // pending switch away from a fast source keeps its old clock; with stop set, idle_mode halts the
    // internal fast RC and fast crystal oscillators at once, even one driving the output.
    assign active_slow = active_src_reg == clk_sel_pkg::SEL_SRC ||
                         active_src_reg == clk_sel_pkg::SEL_SXT;
    assign halt = stop && (idle_mode || (!mode && active_slow));

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            internal_fast_rc_en <= 1'b1;
            fast_crystal_en <= 1'b0;
            alternative_rc_fast_en <= 1'b0;
            internal_slow_rc_en <= 1'b1;
            slow_crystal_en <= 1'b0;
            fast_crystal_pins <= 1'b0;
            slow_crystal_pins <= 1'b0;
        end else begin
            internal_fast_rc_en <= (!fsub || active_src_reg == clk_sel_pkg::SEL_FRC) &&
                                   !halt;
            fast_crystal_en <= (fsub || active_src_reg == clk_sel_pkg::SEL_FXT) &&
                               !halt;
            alternative_rc_fast_en <= ftype || active_src_reg == clk_sel_pkg::SEL_RFC;
            internal_slow_rc_en <= !stype || active_src_reg == clk_sel_pkg::SEL_SRC;
            slow_crystal_en <= stype || active_src_reg == clk_sel_pkg::SEL_SXT;
            fast_crystal_pins <= fsub;
            slow_crystal_pins <= stype;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_fast_sub_path: assert property (
        state_reg == clk_sel_pkg::st_run && $stable(ctrl_reg) && mode && !ftype
        |-> active_src_reg == (fsub ? clk_sel_pkg::SEL_FXT : clk_sel_pkg::SEL_FRC))
        else $error("fast sub-clock not driving the system clock");

    a_slow_mode_path: assert property (
        state_reg == clk_sel_pkg::st_run && $stable(ctrl_reg) && !mode |-> active_slow)
        else $error("slow mode not driven from a slow source");

    a_mode_write_gate: assert property (
        ctrl_wr && stop && !ftype |=> $stable(mode))
        else $error("clock mode changed while the fast oscillators are stopped");

    a_slow_crystal_pins: assert property (
        stype |=> slow_crystal_pins && slow_crystal_en)
        else $error("slow crystal not enabled on its pins");

    a_fast_osc_halt: assert property (
        halt |=> !internal_fast_rc_en && !fast_crystal_en)
        else $error("fast oscillators still running under stop");

    a_fast_crystal_pins: assert property (
        fsub && !halt |=> fast_crystal_pins && fast_crystal_en)
        else $error("fast crystal not enabled on its pins");

    a_type_write_gate: assert property (
        ctrl_wr && mode |=> $stable(ftype))
        else $error("fast clock type changed in fast mode");

    a_div_count_bound: assert property (
        edge_cnt_reg <= half_m1(active_psc_reg))
        else $error("prescaler count beyond its ratio");

    a_div_toggle_cause: assert property (
        $changed(sys_clk_out) |-> $past(src_edge) && $past(edge_cnt_reg) ==
        $past(half_m1(active_psc_reg)))
        else $error("system clock toggled off a ratio boundary");

    a_switch_at_fall: assert property (
        $changed(active_src_reg) || $changed(active_psc_reg) |-> $fell(sys_clk_out))
        else $error("source switched outside a falling system clock edge");

    c_go_fast: cover property ($rose(mode));
    c_switch_done: cover property (state_reg == clk_sel_pkg::st_switch ##1
                                   state_reg == clk_sel_pkg::st_run);
    c_mode_refused: cover property (ctrl_wr && stop && !ftype &&
                                    wdata_reg[clk_sel_pkg::MODE_BIT] != mode);
    c_status_read: cover property (rvalid && rready && rdata[6]);

endmodule : system_clock_select
